// file: verilog/mdio_defs.svh
// constants of the motor driver discrete i/o block
`ifndef MDIO_DEFS_SVH
`define MDIO_DEFS_SVH

// clock rate and least input level time
`define MDIO_CLK_MHZ 200
`define MDIO_IN_MIN_US 10000
`define MDIO_FILTER_CYCLES (`MDIO_IN_MIN_US * `MDIO_CLK_MHZ)
`define MDIO_FILT_CNT_W 24

// speed pulse output rate and default motor steps per revolution
`define MDIO_PULSES_PER_REV 30
`define MDIO_STEPS_PER_REV 60

// register byte offsets
`define MDIO_REG_CTRL 8'h00
`define MDIO_REG_IN_MAP 8'h04
`define MDIO_REG_OUT_MAP 8'h08
`define MDIO_REG_SPD_WIDTH 8'h0C
`define MDIO_REG_STATUS 8'h10

// register fields and reset values
`define MDIO_CTRL_TWO_WIRE 0
`define MDIO_IN_MAP_RST 24'h543210
`define MDIO_OUT_MAP_RST 20'h18820
`define MDIO_SPD_WIDTH_RST 16'h0032
`define MDIO_OUT_TERM_RST 4'h2

// axi responses
`define MDIO_RESP_OKAY 2'h0
`define MDIO_RESP_SLVERR 2'h2

// input function codes, one 4-bit code per input terminal
`define MDIO_FN_RUN_DECEL 4'h0
`define MDIO_FN_RUN_HALT 4'h1
`define MDIO_FN_DIR_SEL 4'h2
`define MDIO_FN_DS0 4'h3
`define MDIO_FN_DS1 4'h4
`define MDIO_FN_FAULT_CLR 4'h5
`define MDIO_FN_FWD_RUN 4'h6
`define MDIO_FN_BWD_RUN 4'h7
`define MDIO_FN_STOP_SEL 4'h8
`define MDIO_FN_DS2 4'h9
`define MDIO_FN_TORQUE_SEL 4'hA
`define MDIO_FN_NOTICE_CLR 4'hB
`define MDIO_FN_UNLOCK 4'hC
`define MDIO_FN_FORCED 4'hD

`endif

// file: verilog/mdio_pkg.sv
// types of the motor driver discrete i/o block
package mdio_pkg;

  typedef enum logic [1:0] {MDIO_HALT_ST, MDIO_RUN_ST, MDIO_DECEL_ST} mdio_motion_type;

  // commands toward the motor control core
  typedef struct packed {
    logic run;
    logic reverse;
    logic decel_stop;
    logic instant_stop;
    logic [2:0] data_number;
    logic torque_limit_en;
    logic tool_unlock;
  } mdio_motor_cmd_type;

  // feedback from the motor control core
  typedef struct packed {
    logic step;
    logic step_fwd;
    logic rotating;
    logic torque_limiting;
    logic alarm_cause;
    logic [7:0] notice_cond;
    logic [15:0] speed_meas;
    logic [15:0] target_speed;
  } mdio_motor_fb_type;

  // whole state of the block
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] filt;
    logic [5:0][23:0] cnt;
    logic fclr_prev;
    logic nclr_prev;
    logic alarm;
    logic [7:0] notice;
    mdio_motion_type mot;
    logic dir_out;
    logic spd_pulse;
    logic [15:0] step_cnt;
    logic two_wire;
    logic [23:0] in_map;
    logic [19:0] out_map;
    logic [15:0] spd_width;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] out_term;
    mdio_motor_cmd_type cmd;
  } mdio_state_type;

endpackage : mdio_pkg

// file: verilog/mdio_io.sv
// discrete control inputs and status outputs of the motor driver
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mdio_defs.svh"

module mdio_io
  import mdio_pkg::*;
#(
  parameter int FILTER_CYCLES = `MDIO_FILTER_CYCLES,
  parameter int STEPS_PER_REV = `MDIO_STEPS_PER_REV
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [5:0] input_terminal,
  output logic [3:0] output_terminal,
  input wire mdio_motor_fb_type motor_fb,
  output mdio_motor_cmd_type motor_cmd
);

  localparam int TOG_STEPS = STEPS_PER_REV / (2 * `MDIO_PULSES_PER_REV);
  localparam logic [23:0] FILT_LAST = 24'(FILTER_CYCLES - 1);
  localparam logic [15:0] TOG_LAST = 16'(TOG_STEPS - 1);

  // refuse settings the counters cannot serve
  if (FILTER_CYCLES < 1 || FILTER_CYCLES >= (1 << `MDIO_FILT_CNT_W))
  begin : g_filt_chk
    $error("filter length out of range");
  end
  if (TOG_STEPS < 1 || STEPS_PER_REV % (2 * `MDIO_PULSES_PER_REV) != 0)
  begin : g_step_chk
    $error("steps per revolution must be a multiple of 60");
  end

  // level of one input function, or-ed over every terminal mapped to it
  function automatic logic fn_level(input logic [23:0] map, input logic [5:0] lvl,
                                    input logic [3:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      if (map[i*4 +: 4] == code)
        r = r | lvl[i];
    end
    return r;
  endfunction : fn_level

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[b*8 +: 8] = data[b*8 +: 8];
    end
    return r;
  endfunction : merge

  mdio_state_type s_reg, s_next;
  logic run_decel, run_halt, dir_sel, fwd_run, bwd_run, stop_sel, forced;
  logic fclr_edge, nclr_edge, run_req, instant_req, fwd_req, reached;
  logic [15:0] spd_diff;
  logic [31:0] src, status, wr_word;

  // decoded input functions from the filtered terminal levels
  assign run_decel = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_RUN_DECEL);
  assign run_halt = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_RUN_HALT);
  assign dir_sel = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_DIR_SEL);
  assign fwd_run = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_FWD_RUN);
  assign bwd_run = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_BWD_RUN);
  assign stop_sel = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_STOP_SEL);
  assign forced = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_FORCED);
  assign fclr_edge = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_FAULT_CLR)
                     & ~s_reg.fclr_prev;
  assign nclr_edge = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_NOTICE_CLR)
                     & ~s_reg.nclr_prev;

  // speed window compare, magnitude of the error against the set speed
  assign spd_diff = (motor_fb.speed_meas >= motor_fb.target_speed)
                    ? motor_fb.speed_meas - motor_fb.target_speed
                    : motor_fb.target_speed - motor_fb.speed_meas;
  assign reached = motor_fb.rotating && spd_diff <= s_reg.spd_width;

  // run request and stop kind for either wiring mode
  always_comb
  begin
    if (s_reg.two_wire)
    begin
      run_req = fwd_run ^ bwd_run;
      fwd_req = fwd_run;
      instant_req = stop_sel && !run_req;
    end
    else
    begin
      run_req = run_decel && run_halt;
      fwd_req = dir_sel;
      instant_req = !run_halt;
    end
  end

  // selectable output sources; codes above the notices read as off
  assign src = {16'h0000, s_reg.notice, reached, |s_reg.notice, motor_fb.rotating,
                s_reg.alarm, s_reg.dir_out, motor_fb.torque_limiting, ~s_reg.alarm,
                s_reg.spd_pulse};

  assign status = {14'h0000, reached, s_reg.cmd.run, s_reg.notice, s_reg.dir_out,
                   s_reg.alarm, s_reg.filt};

  // handshakes come straight from the hold flags
  assign awready = !s_reg.aw_held;
  assign wready = !s_reg.w_held;
  assign arready = !s_reg.rvalid;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign output_terminal = s_reg.out_term;
  assign motor_cmd = s_reg.cmd;

  always_comb
  begin
    s_next = s_reg;
    wr_word = 32'h00000000;

    // two flops, then a level must hold a whole filter span to be taken
    s_next.sync1 = input_terminal;
    s_next.sync2 = s_reg.sync1;
    for (int i = 0; i < 6; i++)
    begin
      if (s_reg.sync2[i] == s_reg.filt[i])
        s_next.cnt[i] = 24'h000000;
      else if (s_reg.cnt[i] == FILT_LAST)
      begin
        s_next.filt[i] = s_reg.sync2[i];
        s_next.cnt[i] = 24'h000000;
      end
      else
        s_next.cnt[i] = s_reg.cnt[i] + 24'h000001;
    end
    s_next.fclr_prev = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_FAULT_CLR);
    s_next.nclr_prev = fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_NOTICE_CLR);

    // alarm latch: clear only once the cause is gone, a new cause wins
    if (fclr_edge && !motor_fb.alarm_cause)
      s_next.alarm = 1'b0;
    if (motor_fb.alarm_cause)
      s_next.alarm = 1'b1;

    // notice latches, same set-over-clear order
    if (nclr_edge)
      s_next.notice = 8'h00;
    s_next.notice = s_next.notice | motor_fb.notice_cond;

    // direction output follows the last rotation actually seen
    if (motor_fb.step)
      s_next.dir_out = motor_fb.step_fwd;

    // speed pulse toggles every TOG_STEPS motor steps
    if (motor_fb.step)
    begin
      if (s_reg.step_cnt == TOG_LAST)
      begin
        s_next.step_cnt = 16'h0000;
        s_next.spd_pulse = !s_reg.spd_pulse;
      end
      else
        s_next.step_cnt = s_reg.step_cnt + 16'h0001;
    end

    // motion sequencer; forced halt and alarms stop without a ramp
    unique case (s_reg.mot)
      MDIO_RUN_ST:
      begin
        if (!run_req)
          s_next.mot = instant_req ? MDIO_HALT_ST : MDIO_DECEL_ST;
      end
      MDIO_DECEL_ST:
      begin
        if (instant_req || !motor_fb.rotating)
          s_next.mot = MDIO_HALT_ST;
        else if (run_req)
          s_next.mot = MDIO_RUN_ST;
      end
      MDIO_HALT_ST:
      begin
        if (run_req)
          s_next.mot = MDIO_RUN_ST;
      end
    endcase
    if (forced || s_next.alarm)
      s_next.mot = MDIO_HALT_ST;

    // commands track the next motion state so they land with it
    s_next.cmd.run = s_next.mot == MDIO_RUN_ST;
    s_next.cmd.decel_stop = s_next.mot == MDIO_DECEL_ST;
    s_next.cmd.instant_stop = s_next.mot == MDIO_HALT_ST;
    if (run_req)
      s_next.cmd.reverse = !fwd_req;
    s_next.cmd.data_number = {fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_DS2),
                              fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_DS1),
                              fn_level(s_reg.in_map, s_reg.filt, `MDIO_FN_DS0)};
    s_next.cmd.torque_limit_en = fn_level(s_reg.in_map, s_reg.filt,
                                          `MDIO_FN_TORQUE_SEL);
    s_next.cmd.tool_unlock = fn_level(s_reg.in_map, s_reg.filt,
                                      `MDIO_FN_UNLOCK);

    // output terminals pick a source each; registered to stay glitch free
    for (int t = 0; t < 4; t++)
      s_next.out_term[t] = src[s_reg.out_map[t*5 +: 5]];

    // axi write: address and data taken in either order, answer after both
    if (awvalid && !s_reg.aw_held)
    begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && !s_reg.w_held)
    begin
      s_next.w_held = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid)
    begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `MDIO_RESP_OKAY;
      unique case (s_reg.aw_addr)
        `MDIO_REG_CTRL:
        begin
          wr_word = merge({31'h00000000, s_reg.two_wire}, s_reg.w_data, s_reg.w_strb);
          s_next.two_wire = wr_word[`MDIO_CTRL_TWO_WIRE];
        end
        `MDIO_REG_IN_MAP:
        begin
          wr_word = merge({8'h00, s_reg.in_map}, s_reg.w_data, s_reg.w_strb);
          s_next.in_map = wr_word[23:0];
        end
        `MDIO_REG_OUT_MAP:
        begin
          wr_word = merge({12'h000, s_reg.out_map}, s_reg.w_data, s_reg.w_strb);
          s_next.out_map = wr_word[19:0];
        end
        `MDIO_REG_SPD_WIDTH:
        begin
          wr_word = merge({16'h0000, s_reg.spd_width}, s_reg.w_data, s_reg.w_strb);
          s_next.spd_width = wr_word[15:0];
        end
        `MDIO_REG_STATUS: ; // read only, write dropped
        default: s_next.bresp = `MDIO_RESP_SLVERR;
      endcase
    end

    // axi read: data one cycle after the address is taken
    if (s_reg.rvalid && rready)
      s_next.rvalid = 1'b0;
    if (arvalid && !s_reg.rvalid)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `MDIO_RESP_OKAY;
      unique case (araddr)
        `MDIO_REG_CTRL: s_next.rdata = {31'h00000000, s_reg.two_wire};
        `MDIO_REG_IN_MAP: s_next.rdata = {8'h00, s_reg.in_map};
        `MDIO_REG_OUT_MAP: s_next.rdata = {12'h000, s_reg.out_map};
        `MDIO_REG_SPD_WIDTH: s_next.rdata = {16'h0000, s_reg.spd_width};
        `MDIO_REG_STATUS: s_next.rdata = status;
        default:
        begin
          s_next.rdata = 32'h00000000;
          s_next.rresp = `MDIO_RESP_SLVERR;
        end
      endcase
    end
  end

  // one register for the whole state; halt and fault-free outputs at reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.in_map <= `MDIO_IN_MAP_RST;
      s_reg.out_map <= `MDIO_OUT_MAP_RST;
      s_reg.spd_width <= `MDIO_SPD_WIDTH_RST;
      s_reg.out_term <= `MDIO_OUT_TERM_RST;
      s_reg.cmd.instant_stop <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  forced_halt_a: assert property (forced |=> s_reg.cmd.instant_stop && !s_reg.cmd.run)
    else $error("forced halt did not stop the motor");
  decel_brake_a: assert property (s_reg.mot == MDIO_DECEL_ST && !s_reg.two_wire
                                  && !run_halt |=> s_reg.mot == MDIO_HALT_ST)
    else $error("halt input ignored during deceleration");
  run_three_a: assert property (!s_reg.two_wire && run_decel && run_halt && !forced
                                && !s_reg.alarm && !motor_fb.alarm_cause
                                |=> s_reg.cmd.run)
    else $error("3-wire run not granted");
  fault_hold_a: assert property (s_reg.alarm && !fclr_edge |=> s_reg.alarm)
    else $error("alarm dropped without fault clear");
  fault_set_a: assert property (motor_fb.alarm_cause |=> s_reg.alarm ##1 !s_reg.out_term[1]
                                || s_reg.out_map[9:5] != 5'h01)
    else $error("alarm not raised on cause");
  dir_track_a: assert property (motor_fb.step |=> s_reg.dir_out == $past(motor_fb.step_fwd))
    else $error("direction output did not follow rotation");
  dir_hold_a: assert property (!motor_fb.step |=> $stable(s_reg.dir_out))
    else $error("direction output moved without rotation");
  pulse_step_a: assert property ($changed(s_reg.spd_pulse) |-> $past(motor_fb.step))
    else $error("speed pulse moved without a motor step");
  // a clear that lands one cycle after the set shows its effect one cycle later
  notice_set_a: assert property (motor_fb.notice_cond[0] |=> s_reg.notice[0]
                                 ##1 s_reg.notice[0] || $past(nclr_edge))
    else $error("notice condition not latched");
endmodule : mdio_io

// file: verif/mdio_motor_model.sv
// behavioural model of the motor control core behind the discrete i/o block
`timescale 1ns/1ps
module mdio_motor_model
  import mdio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire mdio_motor_cmd_type motor_cmd,
  input wire logic torque_limiting,
  input wire logic alarm_cause,
  input wire logic [7:0] notice_cond,
  input wire logic [15:0] speed_meas,
  input wire logic [15:0] target_speed,
  output mdio_motor_fb_type motor_fb
);
  logic rot_reg;
  logic [1:0] ph_reg;
  logic [5:0] slow_reg;

  // coasts 40 cycles on a deceleration stop, long enough for a halt to cut it short
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rot_reg <= 1'h0;
      ph_reg <= 2'h0;
      slow_reg <= 6'h00;
    end
    else
    begin
      ph_reg <= ph_reg + 2'h1;
      if (motor_cmd.instant_stop)
        rot_reg <= 1'h0;
      else if (motor_cmd.run)
      begin
        rot_reg <= 1'h1;
        slow_reg <= 6'h28;
      end
      else if (motor_cmd.decel_stop && rot_reg)
      begin
        slow_reg <= slow_reg - 6'h01;
        rot_reg <= (slow_reg != 6'h00);
      end
    end
  end

  // one step every fourth cycle while turning, in the commanded direction
  always_comb
  begin
    motor_fb.step = rot_reg && (ph_reg == 2'h3);
    motor_fb.step_fwd = !motor_cmd.reverse;
    motor_fb.rotating = rot_reg;
    motor_fb.torque_limiting = torque_limiting;
    motor_fb.alarm_cause = alarm_cause;
    motor_fb.notice_cond = notice_cond;
    motor_fb.speed_meas = speed_meas;
    motor_fb.target_speed = target_speed;
  end
endmodule : mdio_motor_model

// file: verif/mdio_io_bench.sv
// self-checking bench of the motor driver discrete i/o block
`timescale 1ns/1ps
`include "mdio_defs.svh"
module mdio_io_bench
  import mdio_pkg::*;
();
  localparam int FILT = 4;
  localparam int SPR = 120;
  localparam int LIMIT = 20000;
  localparam int EXP_RISES = 240 * 30 / SPR;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0;
  logic awready;
  logic [7:0] awaddr = 8'h00;
  logic wvalid = 1'h0;
  logic wready;
  logic [31:0] wdata = 32'h0;
  logic bvalid;
  logic bready = 1'h0;
  logic [1:0] bresp;
  logic arvalid = 1'h0;
  logic arready;
  logic [7:0] araddr = 8'h00;
  logic rvalid;
  logic rready = 1'h0;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [5:0] input_terminal = 6'h00;
  logic [3:0] output_terminal;
  mdio_motor_fb_type motor_fb;
  mdio_motor_cmd_type motor_cmd;
  logic tlim = 1'h0;
  logic alarm_c = 1'h0;
  logic [7:0] notice_c = 8'h00;
  logic [15:0] meas = 16'h0000;
  logic [15:0] tgt = 16'h03E8;
  logic [15:0] spd [3] = '{16'h0406, 16'h0424, 16'h03C0};
  logic pulse_prev = 1'h0;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_steps = 0;
  int n_rises = 0;

  always #2.5 aclk = ~aclk;

  mdio_io #(.FILTER_CYCLES(FILT), .STEPS_PER_REV(SPR)) dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .input_terminal(input_terminal),
    .output_terminal(output_terminal), .motor_fb(motor_fb), .motor_cmd(motor_cmd)
  );

  mdio_motor_model core (
    .aclk(aclk), .aresetn(aresetn), .motor_cmd(motor_cmd), .torque_limiting(tlim),
    .alarm_cause(alarm_c), .notice_cond(notice_c), .speed_meas(meas), .target_speed(tgt),
    .motor_fb(motor_fb)
  );

  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // address and data offered together, each dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (awready === 1'h1 && !aw_done)
      begin
        aw_done = 1'h1;
        awvalid <= 1'h0;
      end
      if (wready === 1'h1 && !w_done)
      begin
        w_done = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do
      @(posedge aclk);
    while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk(bresp, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
      @(posedge aclk);
    while (arready !== 1'h1);
    arvalid <= 1'h0;
    do
      @(posedge aclk);
    while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, exp);
    chk(rresp, er);
  endtask : rd

  // holds each level well past the filter time before anything is judged
  task automatic sin(input logic [5:0] v);
    input_terminal <= v;
    repeat (FILT + 8) @(posedge aclk);
  endtask : sin

  // timeout, plus step and speed pulse counts for the pulse rate check
  always @(posedge aclk)
  begin
    cycles++;
    if (motor_fb.step === 1'h1)
      n_steps++;
    if (output_terminal[0] === 1'h1 && pulse_prev === 1'h0)
      n_rises++;
    pulse_prev = output_terminal[0];
    if (cycles == LIMIT)
    begin
      n_errors++;
      stop_test();
    end
  end

  initial
  begin
    int s0;
    int r0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(output_terminal, 4'h2);
    rd(`MDIO_REG_CTRL, 32'h0, `MDIO_RESP_OKAY);
    rd(`MDIO_REG_IN_MAP, 32'h00543210, `MDIO_RESP_OKAY);
    rd(`MDIO_REG_OUT_MAP, 32'h00018820, `MDIO_RESP_OKAY);
    rd(`MDIO_REG_SPD_WIDTH, 32'h00000032, `MDIO_RESP_OKAY);
    rd(8'h20, 32'h0, `MDIO_RESP_SLVERR);
    wr(8'h20, 32'hFFFFFFFF, `MDIO_RESP_SLVERR);
    wr(`MDIO_REG_STATUS, 32'hFFFFFFFF, `MDIO_RESP_OKAY);
    // a two-cycle pulse on both run inputs is shorter than the filter
    input_terminal <= 6'h03;
    repeat (2) @(posedge aclk);
    input_terminal <= 6'h00;
    repeat (12) @(posedge aclk);
    chk(motor_cmd.run, 1'h0);
    for (int i = 0; i < 4; i++)
    begin
      sin({1'h0, i[1:0], 3'h0});
      chk(motor_cmd.data_number, i[2:0]);
    end
    // forward run, then count speed pulses over two revolutions
    sin(6'h07);
    chk(motor_cmd.run, 1'h1);
    chk(motor_cmd.reverse, 1'h0);
    s0 = n_steps;
    r0 = n_rises;
    while (n_steps - s0 < 240)
      @(posedge aclk);
    chk((n_rises - r0 >= EXP_RISES - 1) && (n_rises - r0 <= EXP_RISES + 1), 1'h1);
    chk(output_terminal[3], 1'h1);
    sin(6'h03);
    chk(motor_cmd.reverse, 1'h1);
    repeat (20) @(posedge aclk);
    chk(output_terminal[3], 1'h0);
    sin(6'h02);
    chk(motor_cmd.decel_stop, 1'h1);
    repeat (60) @(posedge aclk);
    chk(motor_cmd.instant_stop, 1'h1);
    sin(6'h03);
    sin(6'h02);
    sin(6'h00);
    chk(motor_cmd.instant_stop, 1'h1);
    sin(6'h03);
    sin(6'h01);
    chk(motor_cmd.instant_stop, 1'h1);
    // terminals: motion, fault nc, fault no, notice summary
    wr(`MDIO_REG_OUT_MAP, 32'h00031025, `MDIO_RESP_OKAY);
    sin(6'h03);
    chk(output_terminal, 4'h3);
    alarm_c <= 1'h1;
    @(posedge aclk);
    alarm_c <= 1'h0;
    repeat (4) @(posedge aclk);
    chk(output_terminal[2:1], 2'h2);
    repeat (30) @(posedge aclk);
    chk(output_terminal, 4'h4);
    rd(`MDIO_REG_STATUS, 32'h00000043, `MDIO_RESP_OKAY);
    sin(6'h23);
    chk(output_terminal[2:1], 2'h1);
    wr(`MDIO_REG_IN_MAP, 32'h00D93210, `MDIO_RESP_OKAY);
    sin(6'h13);
    chk(motor_cmd.data_number, 3'h4);
    sin(6'h33);
    chk(motor_cmd.instant_stop, 1'h1);
    // two-wire map: fwd, bwd, stop select, torque select, notice clear, unlock
    wr(`MDIO_REG_CTRL, 32'h1, `MDIO_RESP_OKAY);
    wr(`MDIO_REG_IN_MAP, 32'h00CBA876, `MDIO_RESP_OKAY);
    wr(`MDIO_REG_OUT_MAP, 32'h000320E2, `MDIO_RESP_OKAY);
    sin(6'h01);
    chk({motor_cmd.run, motor_cmd.reverse}, 2'h2);
    sin(6'h02);
    chk({motor_cmd.run, motor_cmd.reverse}, 2'h3);
    sin(6'h00);
    chk(motor_cmd.decel_stop, 1'h1);
    repeat (60) @(posedge aclk);
    sin(6'h01);
    sin(6'h04);
    chk(motor_cmd.instant_stop, 1'h1);
    sin(6'h01);
    for (int k = 0; k < 3; k++)
    begin
      meas <= spd[k];
      repeat (4) @(posedge aclk);
      chk(output_terminal[1], (spd[k] >= 16'h03B6) && (spd[k] <= 16'h041A));
    end
    tlim <= 1'h1;
    repeat (4) @(posedge aclk);
    chk(output_terminal[0], 1'h1);
    tlim <= 1'h0;
    repeat (4) @(posedge aclk);
    chk(output_terminal[0], 1'h0);
    notice_c <= 8'h01;
    @(posedge aclk);
    notice_c <= 8'h00;
    repeat (4) @(posedge aclk);
    chk(output_terminal[3:2], 2'h3);
    sin(6'h11);
    chk(output_terminal[3:2], 2'h0);
    sin(6'h28);
    chk({motor_cmd.torque_limit_en, motor_cmd.tool_unlock}, 2'h3);
    sin(6'h00);
    chk({motor_cmd.torque_limit_en, motor_cmd.tool_unlock}, 2'h0);
    stop_test();
  end
endmodule : mdio_io_bench
